// ===== bench/dpa_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module dpa_asserts (
	// clock and resets
	input wire logic MCLK_IN,
	input wire logic NRST_IN,
	input wire logic SYNC_RESET_N_IN,
	// requests
	input wire logic FIRST_PORT_REQUEST_N_IN,
	input wire logic FIRST_PORT_SELECT_N_IN,
	input wire logic REFRESH_REQUEST_N_IN,
	input wire logic LOCK_N_IN,
	input wire logic SECOND_PORT_REQUEST_N_OUT,
	// grants and strobe
	input wire logic FIRST_PORT_GRANT_N_OUT,
	input wire logic SECOND_PORT_GRANT_N_OUT,
	input wire logic REFRESH_GRANT_N_OUT,
	input wire logic GRANT_DELAYED_N_OUT,
	input wire logic ROW_STROBE_IN_N_OUT,
	input wire logic FIRST_PORT_WAIT_N_OUT
);
	wire logic ga = !FIRST_PORT_GRANT_N_OUT;
	wire logic gb = !SECOND_PORT_GRANT_N_OUT;
	wire logic grf = !REFRESH_GRANT_N_OUT;
	wire logic a_asks = !FIRST_PORT_REQUEST_N_IN && !FIRST_PORT_SELECT_N_IN;
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (!NRST_IN || !SYNC_RESET_N_IN);
	sequence s_new_first;
		$rose(ga);
	endsequence
	sequence s_precharge;
		ROW_STROBE_IN_N_OUT [*2];
	endsequence
	a_refresh_start: assert property (!ga && !gb && !REFRESH_REQUEST_N_IN |=> grf)
		else $error("refresh not granted while idle");
	a_delayed_one: assert property ($rose(ga || gb || grf) |-> GRANT_DELAYED_N_OUT ##1 !GRANT_DELAYED_N_OUT)
		else $error("delayed grant not one period after grant");
	a_single_grant: assert property ($countones({ga, gb, grf}) < 2)
		else $error("two grants at once");
	a_strobe_owner: assert property (!ROW_STROBE_IN_N_OUT |-> !grf && (ga || gb))
		else $error("row strobe without a port grant");
	a_lock_hold: assert property (!LOCK_N_IN && gb |=> gb)
		else $error("locked grant released");
	a_first_win: assert property (a_asks && REFRESH_REQUEST_N_IN && !grf && !gb |=> ga)
		else $error("first port not granted");
	a_park_first: assert property (ga && SECOND_PORT_REQUEST_N_OUT && REFRESH_REQUEST_N_IN |=> ga)
		else $error("parked grant dropped");
	a_wait_busy: assert property (a_asks && (gb || grf) |-> !FIRST_PORT_WAIT_N_OUT)
		else $error("no wait while memory busy");
	a_precharge_gap: assert property (s_new_first |-> s_precharge)
		else $error("strobe too soon after hand-over");
endmodule
`default_nettype wire

// ===== bench/dpa_port_model.sv
`timescale 1ns/10ps
`default_nettype none
module dpa_port_model (
	// bench commands
	input  wire logic a_go_in,
	input  wire logic a_wr_in,
	input  wire logic b_go_in,
	// arbiter side
	input  wire logic SECOND_PORT_GRANT_N_OUT,
	input  wire logic ROW_STROBE_IN_N_OUT,
	output logic      FIRST_PORT_REQUEST_N_IN,
	output logic      FIRST_PORT_SELECT_N_IN,
	output logic      FIRST_PORT_WRITE_N_IN,
	output logic      SECOND_PORT_ASYNC_REQUEST_N_IN,
	output logic      second_ack_n_out
);
	assign FIRST_PORT_REQUEST_N_IN = !a_go_in;
	assign FIRST_PORT_SELECT_N_IN = !a_go_in;
	assign FIRST_PORT_WRITE_N_IN = !a_wr_in;
	// skewed off the clock, as a foreign bus would be
	assign #1 SECOND_PORT_ASYNC_REQUEST_N_IN = !b_go_in;
	// ack made out here, not by the arbiter
	assign second_ack_n_out = SECOND_PORT_GRANT_N_OUT | ROW_STROBE_IN_N_OUT;
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic MCLK_IN = 1'b0, NRST_IN = 1'b0, SYNC_RESET_N_IN = 1'b1;
	logic REFRESH_REQUEST_N_IN = 1'b1, LOCK_N_IN = 1'b1;
	logic a_go_in = 1'b0, a_wr_in = 1'b0, b_go_in = 1'b0;
	wire logic FIRST_PORT_REQUEST_N_IN, FIRST_PORT_SELECT_N_IN, FIRST_PORT_WRITE_N_IN;
	wire logic SECOND_PORT_ASYNC_REQUEST_N_IN, second_ack_n_out, SECOND_PORT_REQUEST_N_OUT;
	wire logic FIRST_PORT_GRANT_N_OUT, SECOND_PORT_GRANT_N_OUT, REFRESH_GRANT_N_OUT;
	wire logic GRANT_DELAYED_N_OUT, ROW_STROBE_IN_N_OUT, FIRST_PORT_WAIT_N_OUT, LOCK_OVERRUN_N_OUT;
	wire logic SWITCH_TO_FIRST_PORT_N_OUT, SWITCH_TO_SECOND_PORT_N_OUT, SWITCH_TO_REFRESH_N_OUT;
	wire logic idle_n = &{FIRST_PORT_GRANT_N_OUT, SECOND_PORT_GRANT_N_OUT, REFRESH_GRANT_N_OUT, GRANT_DELAYED_N_OUT};
	int mismatches = 0, total_checks = 0, n_rd, n_wr, n;
	always #2 MCLK_IN = !MCLK_IN;
	dpa_arbiter i_dpa_arbiter (.*);
	dpa_port_model i_dpa_port_model (.*);
	task automatic check(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %b wanted %b", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge MCLK_IN);
	endtask
	// polls half a step after the call, so clear of the clock edges only when called on a whole step
	task automatic strobe_to(input logic lvl, output int steps);
		#0.5;
		for (steps = 0; steps < 60 && ROW_STROBE_IN_N_OUT !== lvl; steps++)
			#1;
		if (steps == 60) begin
			mismatches++;
			end_of_test;
		end
	endtask
	task automatic a_access(input logic wr, output int lat);
		a_wr_in = wr;
		a_go_in = 1'b1;
		strobe_to(1'b0, lat);
		cyc(1);
		a_go_in = 1'b0;
		strobe_to(1'b1, n);
		check(n == 4, 1'b1);
		cyc(1);
		a_wr_in = 1'b0;
	endtask
	// held two cycles: a one-cycle request never sees the delayed grant
	task automatic refresh;
		REFRESH_REQUEST_N_IN = 1'b0;
		cyc(1);
		check(REFRESH_GRANT_N_OUT, 1'b0);
		cyc(1);
		REFRESH_REQUEST_N_IN = 1'b1;
		cyc(4);
	endtask
	task automatic t_first;
		a_access(1'b0, n_rd);
		refresh;
		a_access(1'b1, n_wr);
		check(n_wr - n_rd == 2, 1'b1);
		cyc(6);
		check(FIRST_PORT_GRANT_N_OUT, 1'b0);
		a_access(1'b0, n);
		check(n == 2, 1'b1);
	endtask
	task automatic t_second;
		b_go_in = 1'b1;
		cyc(2);
		#1;
		check(SECOND_PORT_REQUEST_N_OUT, 1'b1);
		cyc(1);
		#1;
		check(SECOND_PORT_REQUEST_N_OUT, 1'b1);
		cyc(1);
		#1;
		check(SECOND_PORT_REQUEST_N_OUT, 1'b0);
		strobe_to(1'b0, n);
		check(FIRST_PORT_GRANT_N_OUT, 1'b1);
		check(SWITCH_TO_SECOND_PORT_N_OUT, 1'b0);
		check(second_ack_n_out, 1'b0);
		cyc(1);
		b_go_in = 1'b0;
		strobe_to(1'b1, n);
		cyc(1);
	endtask
	task automatic t_lock;
		LOCK_N_IN = 1'b0;
		a_go_in = 1'b1;
		cyc(5);
		check(SECOND_PORT_GRANT_N_OUT, 1'b0);
		check(FIRST_PORT_WAIT_N_OUT, 1'b0);
		check(SWITCH_TO_FIRST_PORT_N_OUT, 1'b1);
		check(LOCK_OVERRUN_N_OUT, 1'b1);
		LOCK_N_IN = 1'b1;
		strobe_to(1'b0, n);
		check(SECOND_PORT_GRANT_N_OUT, 1'b1);
		check(SWITCH_TO_FIRST_PORT_N_OUT, 1'b0);
		cyc(1);
		a_go_in = 1'b0;
		strobe_to(1'b1, n);
		cyc(1);
	endtask
	task automatic t_refresh;
		REFRESH_REQUEST_N_IN = 1'b0;
		#1;
		check(SWITCH_TO_REFRESH_N_OUT, 1'b0);
		cyc(1);
		check(REFRESH_GRANT_N_OUT, 1'b0);
		a_go_in = 1'b1;
		b_go_in = 1'b1;
		cyc(5);
		REFRESH_REQUEST_N_IN = 1'b1;
		strobe_to(1'b0, n);
		check(FIRST_PORT_GRANT_N_OUT, 1'b0);
		cyc(1);
		a_go_in = 1'b0;
		strobe_to(1'b1, n);
		strobe_to(1'b0, n);
		check(SECOND_PORT_GRANT_N_OUT, 1'b0);
		cyc(1);
		b_go_in = 1'b0;
		strobe_to(1'b1, n);
		cyc(1);
	endtask
	task automatic t_sync_reset;
		SYNC_RESET_N_IN = 1'b0;
		cyc(1);
		SYNC_RESET_N_IN = 1'b1;
		check(idle_n, 1'b1);
		refresh;
	endtask
	initial begin
		cyc(5);
		NRST_IN = 1'b1;
		cyc(1);
		check(idle_n & ROW_STROBE_IN_N_OUT & FIRST_PORT_WAIT_N_OUT, 1'b1);
		t_first;
		t_second;
		t_lock;
		t_refresh;
		t_sync_reset;
		end_of_test;
	end
endmodule
bind dpa_arbiter dpa_asserts i_dpa_asserts (.*);
`default_nettype wire

// ===== hdl/dpa_arbiter.sv
// Summary of operation
// [R1] First-port write starts the row strobe half a clock later than a read.
// [R2] First-port strobe ends half a clock after its request goes high.
// [R3] Refresh grant goes low when refresh requested and no port granted.
// [R4] Second-port request is synchronised on the falling clock edge.
// [R5] Asynchronous second-port request passes two flip-flops before use; the code also adds sync3 and a filtered second_request flop.
// [R6] Lock low keeps the granted port granted until lock returns high.
// [R7] Switch-to-first term hands over from second port, second grant dropping first.
// [R8] Switch-to-second term hands over from first port, first grant dropping first.
// [R9] First port asserts select together with request to access memory.
// [R10] All arbiter outputs are active low.
// [R11] Refresh grant drives the controller refresh mode input, forcing refresh.
// [R12] Delayed grant goes low one period after any grant goes low; the code follows the refresh grant only while refresh is still requested.
// [R13] Once the delayed grant is low, further port requests strobe immediately.
// [R14] Wait output holds off first port while memory is busy elsewhere.
// [R15] Switch-to-refresh true when refresh requested and granted port idle, unlocked.
// [R16] Second-port transfer acknowledge is produced outside the arbiter.
// [R17] First port newly granted on select and request, no refresh, second idle.
// [R18] Second-port row strobe is gated by the switch-to-first term.
// [R19] Refresh has highest priority; first port wins over second port.
// [R20] Last-served port stays granted while no other requester asks.
// [R21] At least one and a half clocks of precharge between different requesters.
// [R22] A port holds lock under grant no longer than one refresh period; the code keeps the grant and only flags LOCK_OVERRUN_N_OUT.
// [R23] Synchronous reset clears all grants and the delayed grant to high.
// [R24] Row strobe only for the granted port, never during refresh grant.
`timescale 1ns/10ps
`default_nettype none

module dpa_arbiter (
	// clock and resets
	input  wire logic MCLK_IN,
	input  wire logic NRST_IN,
	input  wire logic SYNC_RESET_N_IN,
	// first port, synchronous to the rising edge
	input  wire logic FIRST_PORT_REQUEST_N_IN,
	input  wire logic FIRST_PORT_SELECT_N_IN,
	input  wire logic FIRST_PORT_WRITE_N_IN,
	// second port, asynchronous, select already folded in
	input  wire logic SECOND_PORT_ASYNC_REQUEST_N_IN,
	// refresh request and shared lock, synchronous
	input  wire logic REFRESH_REQUEST_N_IN,
	input  wire logic LOCK_N_IN,
	// grants
	output logic      FIRST_PORT_GRANT_N_OUT,
	output logic      SECOND_PORT_GRANT_N_OUT,
	output logic      REFRESH_GRANT_N_OUT,
	output logic      GRANT_DELAYED_N_OUT,
	// controller strobe and port handshake
	output logic      ROW_STROBE_IN_N_OUT,
	output logic      FIRST_PORT_WAIT_N_OUT,
	// switch terms and status
	output logic      SWITCH_TO_FIRST_PORT_N_OUT,
	output logic      SWITCH_TO_SECOND_PORT_N_OUT,
	output logic      SWITCH_TO_REFRESH_N_OUT,
	output logic      SECOND_PORT_REQUEST_N_OUT,
	output logic      LOCK_OVERRUN_N_OUT
);

	dpa_pkg::dpa_rise_t rise;
	dpa_pkg::dpa_rise_t next_rise;
	dpa_pkg::dpa_fall_t fall;
	dpa_pkg::dpa_fall_t next_fall;

	// active-high views of the inputs
	logic req_a;
	logic sel_a;
	logic wr_a;
	logic req_b;
	logic ref_req;
	logic locked;
	logic access_a;

	// combinational arbitration terms
	logic to_first;
	logic to_second;
	logic to_refresh;
	logic strobe_a;
	logic strobe_b;
	logic strobe;
	logic start_a;
	logic cont_a;
	logic rf_to_a;
	logic b_to_a;
	logic hold_a;
	logic start_b;
	logic cont_b;
	logic a_to_b;
	logic rf_to_b;
	logic hold_b;
	logic start_rf;
	logic cont_rf;
	logic hold_rf;
	logic port_locked;

	assign req_a    = ~FIRST_PORT_REQUEST_N_IN;
	assign sel_a    = ~FIRST_PORT_SELECT_N_IN;
	assign wr_a     = ~FIRST_PORT_WRITE_N_IN;
	assign req_b    = fall.second_request;
	assign ref_req  = ~REFRESH_REQUEST_N_IN;
	assign locked   = ~LOCK_N_IN;
	assign access_a = req_a & sel_a; // R9

	// hand-over terms, built from requests and lock only
	assign to_first  = access_a & ~req_b & ~locked; // R7
	assign to_second = req_b & ~access_a & ~locked; // R8

	// refresh takes over at the next rising edge
	always_comb begin
		to_refresh = 1'b0;
		if (ref_req & ~locked) begin
			to_refresh = (rise.first_grant & ~req_a) | (rise.second_grant & ~req_b); // R15
		end
	end

	// first port row strobe: the rising-edge half starts reads at once,
	// the falling-edge half starts writes and stretches both past the request
	// reads open on the rising half; writes wait for the falling half,
	// and the falling half also carries both past the end of the request
	assign strobe_a = rise.first_grant & ((rise.rise_strobe & ~wr_a) | fall.fall_strobe); // R1 R2
	// second port strobe waits out the switch term so the grant can flip first
	assign strobe_b = rise.second_grant & rise.grant_delayed & req_b & ~to_first; // R18 R7
	assign strobe   = (strobe_a | strobe_b) & ~rise.refresh_grant; // R24

	// first port grant terms
	always_comb begin
		start_a = access_a & ~rise.refresh_grant & ~ref_req & ~rise.second_grant; // R17 R19
		cont_a  = locked & rise.first_grant; // R6
		rf_to_a = access_a & ~ref_req & rise.refresh_grant & ~rise.grant_delayed; // R21
		b_to_a  = sel_a & to_first & rise.second_grant & ~ref_req & ~strobe; // R7
		// a trailing strobe half keeps the grant so the hand-over cannot cut it
		hold_a  = (access_a & rise.first_grant) | (rise.first_grant & ~req_b & ~ref_req)
			| (rise.first_grant & fall.fall_strobe & ~ref_req); // R20 R2
	end

	// second port grant terms; first port wins any tie
	always_comb begin
		start_b = ~req_a & ~rise.first_grant & ~ref_req & ~rise.refresh_grant & req_b; // R19
		cont_b  = locked & rise.second_grant; // R6
		a_to_b  = to_second & rise.first_grant & ~ref_req & ~strobe; // R8
		rf_to_b = ~req_a & ~ref_req & rise.refresh_grant & req_b & ~rise.grant_delayed; // R21
		hold_b  = (req_b & rise.second_grant)
			| (rise.second_grant & ~req_a & ~ref_req)
			| (rise.second_grant & ~sel_a & ~ref_req); // R20
	end

	// refresh grant terms
	always_comb begin
		start_rf    = ~rise.first_grant & ~rise.second_grant & ref_req; // R3 R19
		cont_rf     = rise.refresh_grant & ref_req;
		port_locked = (rise.first_grant | rise.second_grant) & locked;
		// the refresh cycle is held until the delayed grant has caught up,
		// which also spaces the next port grant for precharge
		hold_rf     = rise.refresh_grant & ~rise.grant_delayed; // R21
	end

	// rising-edge state
	always_comb begin
		next_rise = rise;
		next_rise.first_grant   = start_a | cont_a | rf_to_a | b_to_a | hold_a;
		next_rise.second_grant  = start_b | cont_b | a_to_b | rf_to_b | hold_b;
		next_rise.refresh_grant = start_rf | cont_rf | (to_refresh & ~port_locked) | hold_rf; // R15
		// delayed grant trails a port grant by one period, the refresh grant only while refresh is still requested, and drops on hand-over
		next_rise.grant_delayed = (rise.first_grant & ~to_second & ~to_refresh)
			| (rise.second_grant & ~to_first & ~to_refresh)
			| (rise.refresh_grant & ref_req); // R12
		// access armed on the rising edge once the port is settled in;
		// only reads let it through to the strobe directly
		next_rise.rise_strobe = rise.first_grant & rise.grant_delayed & access_a
			& ~to_second & ~rise.refresh_grant; // R1 R13
		// lock watchdog, saturates at the limit
		if (port_locked) begin
			if (rise.lock_cnt != dpa_pkg::LOCK_LIMIT) begin
				next_rise.lock_cnt = rise.lock_cnt + dpa_pkg::LOCK_CNT_ONE;
			end
		end else begin
			next_rise.lock_cnt = dpa_pkg::RST_LOCK_CNT;
		end
		next_rise.lock_overrun = port_locked & (rise.lock_cnt == dpa_pkg::LOCK_LIMIT); // R22
		if (!SYNC_RESET_N_IN) begin
			next_rise.first_grant   = dpa_pkg::RST_GRANT; // R23
			next_rise.second_grant  = dpa_pkg::RST_GRANT; // R23
			next_rise.refresh_grant = dpa_pkg::RST_GRANT; // R23
			next_rise.grant_delayed = dpa_pkg::RST_DELAYED; // R23
			next_rise.rise_strobe   = dpa_pkg::RST_STROBE;
			next_rise.lock_cnt      = dpa_pkg::RST_LOCK_CNT;
			next_rise.lock_overrun  = 1'b0;
		end
	end

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rise.first_grant   <= dpa_pkg::RST_GRANT;
			rise.second_grant  <= dpa_pkg::RST_GRANT;
			rise.refresh_grant <= dpa_pkg::RST_GRANT;
			rise.grant_delayed <= dpa_pkg::RST_DELAYED;
			rise.rise_strobe   <= dpa_pkg::RST_STROBE;
			rise.lock_cnt      <= dpa_pkg::RST_LOCK_CNT;
			rise.lock_overrun  <= 1'b0;
		end else begin
			rise <= next_rise;
		end
	end

	// falling-edge state: the request lands half a period earlier than a
	// rising-edge synchroniser would give, trading margin for latency
	always_comb begin
		next_fall = fall;
		next_fall.sync1 = SECOND_PORT_ASYNC_REQUEST_N_IN; // R4 R5
		next_fall.sync2 = fall.sync1; // R5
		next_fall.sync3 = fall.sync2;
		if (fall.sync2 == fall.sync3) begin
			next_fall.second_request = ~fall.sync3; // R5
		end
		// late half: covers writes and the half period after the request ends
		// follows the armed rising half, so it never opens before a read
		// and it drops half a period after the request is seen high
		next_fall.fall_strobe = rise.first_grant & rise.rise_strobe; // R1 R2 R13
		if (!SYNC_RESET_N_IN) begin
			next_fall.fall_strobe = dpa_pkg::RST_STROBE;
		end
	end

	always_ff @(negedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			fall.sync1          <= dpa_pkg::RST_SYNC;
			fall.sync2          <= dpa_pkg::RST_SYNC;
			fall.sync3          <= dpa_pkg::RST_SYNC;
			fall.second_request <= 1'b0;
			fall.fall_strobe    <= dpa_pkg::RST_STROBE;
		end else begin
			fall <= next_fall;
		end
	end

	// outputs, every one active low
	always_comb begin
		FIRST_PORT_GRANT_N_OUT      = ~rise.first_grant; // R10
		SECOND_PORT_GRANT_N_OUT     = ~rise.second_grant; // R10
		REFRESH_GRANT_N_OUT         = ~rise.refresh_grant; // R10 R11
		GRANT_DELAYED_N_OUT         = ~rise.grant_delayed; // R10 R12
		ROW_STROBE_IN_N_OUT         = ~strobe; // R10
		SWITCH_TO_FIRST_PORT_N_OUT  = ~to_first;
		SWITCH_TO_SECOND_PORT_N_OUT = ~to_second;
		SWITCH_TO_REFRESH_N_OUT     = ~to_refresh;
		SECOND_PORT_REQUEST_N_OUT   = ~fall.second_request;
		LOCK_OVERRUN_N_OUT          = ~rise.lock_overrun;
		// wait while the first port asks but is not settled in its grant
		FIRST_PORT_WAIT_N_OUT = ~(access_a & ~(rise.first_grant & rise.grant_delayed)); // R14
	end

endmodule

`default_nettype wire

// ===== hdl/dpa_pkg.sv
package dpa_pkg;

	// grant and strobe levels, all active low
	localparam logic GRANT_IDLE      = 1'b1;
	localparam logic GRANT_ON        = 1'b0;
	localparam logic STROBE_IDLE     = 1'b1;

	// reset values of the internal state, active high except the synchroniser, which holds the active-low request
	localparam logic RST_GRANT       = 1'b0;
	localparam logic RST_DELAYED     = 1'b0;
	localparam logic RST_STROBE      = 1'b0;
	localparam logic RST_SYNC        = 1'b1;

	// lock watchdog: lock held under a grant past one refresh period
	localparam int   CLK_PERIOD_PS   = 4000;
	localparam int   LOCK_LIMIT_PS   = 15600000;
	localparam int   LOCK_LIMIT_CYC  = LOCK_LIMIT_PS / CLK_PERIOD_PS;
	localparam int   LOCK_CNT_W      = 12;
	localparam logic [LOCK_CNT_W-1:0] LOCK_LIMIT =
		LOCK_LIMIT_CYC[LOCK_CNT_W-1:0];
	localparam logic [LOCK_CNT_W-1:0] RST_LOCK_CNT = 12'h000;
	localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_ONE = 12'h001;

	// rising-edge arbitration state
	typedef struct packed {
		logic                  first_grant;
		logic                  second_grant;
		logic                  refresh_grant;
		logic                  grant_delayed;
		logic                  rise_strobe;
		logic [LOCK_CNT_W-1:0] lock_cnt;
		logic                  lock_overrun;
	} dpa_rise_t;

	// falling-edge state: request synchroniser and late strobe
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic sync3;
		logic second_request;
		logic fall_strobe;
	} dpa_fall_t;

endpackage
